// file: zoom_pkg.sv
package zoom_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int AD_W = 16;
  localparam int DAD_W = 18;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] AREA_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] START_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] LINE_OFS = 8'h10;

  // Control register fields.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_ZOOM_LSB = 4;
  localparam int ZOOM_W = 4;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;

  // Area parameter bytes: wide access sits in bit 7 of each byte.
  localparam int WIDE_BIT = 7;
  localparam int AREA0_GFX_BYTE = 3;
  localparam int AREA1_GFX_BYTE = 7;
  localparam int AREA0_CHR_BYTE = 11;
  localparam int AREA1_CHR_BYTE = 15;
  localparam logic [DATA_W-1:0] AREA_RST = 32'h0000_0000;

  // Line geometry fields of the line register.
  localparam int WORDS_LSB = 0;
  localparam int LINES_LSB = 16;
  localparam int SPLIT_LSB = 8;
  localparam int GEOM_W = 8;
  localparam logic [DATA_W-1:0] LINE_RST = 32'h0010_0408;

  // Zoom limits.
  localparam int ZOOM_MAX = 16;

  // Response codes.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Display modes.
  typedef enum logic [1:0] {
    MODE_GRAPHICS,
    MODE_CHARACTER,
    MODE_MIXED,
    MODE_RESERVED
  } disp_mode_t;

  // Register bus carriers.
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // Multiplexed address/data pins; the enable is low while driving.
  typedef struct packed {
    logic [AD_W-1:0] ad_out;
    logic [AD_W-1:0] ad_oe_n;
    logic addr_latch;
    logic [DAD_W-1:AD_W] addr_high;
  } mem_pins_t;

endpackage

// file: zoom_cycle_timer.sv
// Paces one display cycle: two base phases plus two phases per extra zoom step.
module zoom_cycle_timer #(
  parameter int ZOOM_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [ZOOM_W-1:0] zoom_m1,
  output logic [ZOOM_W:0] phase,
  output logic cycle_end
);

  logic [ZOOM_W:0] last;

  // Last phase index is twice the zoom factor minus one.
  assign last = {zoom_m1, 1'b1};
  assign cycle_end = run && (phase == last);

  // Phase counter restarts at zero for every display cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      phase <= '0;
    end else if (cycle_end) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

endmodule

// file: zoom_display.sv
// Functional notes
// - Zoom factor from 1 to 16, same magnification in both directions.
// - Zoom applies only in bit-mapped graphics mode.
// - Unzoomed display cycle is two word-clock cycles, phases one and two.
// - Latch strobe falls mid phase one, rises at end of phase two; here it is low for all of phase one and stays low when unzoomed.
// - Address driven during phase one, lines released in phase two.
// - Each zoom step adds two word-clock cycles to the display cycle.
// - Phases one and two fixed; strobe held high from phase three on.
// - Controller repeats each display line zoom-factor times.
// - Wide mode fetches two words per display cycle; drawing stays single word; here each cycle still drives one address and captures one word.
// - Wide mode advances the display word address by two.
// - Wide select per area: bit 7 of byte 3 or 7, or 11 or 15.
// - Wide access also works in character and mixed modes.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
module zoom_display
  import zoom_pkg::*;
#(
  parameter int AREA_W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire zoom_pkg::axil_req_t bus_req,
  output zoom_pkg::axil_rsp_t bus_rsp,
  input wire logic [zoom_pkg::AD_W-1:0] ad_in,
  output zoom_pkg::mem_pins_t pins,
  output logic wide_cycle_r,
  output logic load_window_r
);
  import zoom_pkg::*;

  // Software-visible state.
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] area_r;
  logic [DATA_W-1:0] line_r;
  logic [DAD_W-1:0] start_r;

  // Bus slave state.
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  // Display engine state.
  logic [DAD_W-1:0] dad_r;
  logic [DAD_W-1:0] line_base_r;
  logic [GEOM_W-1:0] word_cnt_r;
  logic [GEOM_W-1:0] line_cnt_r;
  logic [ZOOM_W-1:0] rep_cnt_r;
  logic [AD_W-1:0] ad_out_r;
  logic [AD_W-1:0] ad_oe_n_r;
  logic addr_latch_r;
  logic [DAD_W-1:AD_W] addr_high_r;
  logic [AD_W-1:0] last_word_r;

  logic run;
  logic [ZOOM_W-1:0] zoom_m1;
  logic [ZOOM_W:0] phase;
  logic cycle_end;
  logic area_sel;
  logic wide;
  logic [DAD_W-1:0] step;
  disp_mode_t mode;

  // Byte-lane merge for register writes.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] nv,
                                              input logic [3:0] strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nv[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Picks bit 7 of an area parameter byte held in the area register.
  function automatic logic wide_bit(input logic [DATA_W-1:0] area, input int byte_no);
    // Each parameter byte owns its own lane, so both areas stay independent.
    return area[(byte_no / 4)*8 + WIDE_BIT];
  endfunction

  assign run = ctrl_r[CTRL_EN_BIT];
  assign mode = disp_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  // Magnification is forced to one outside graphics mode.
  assign zoom_m1 = (mode == MODE_GRAPHICS) ? ctrl_r[CTRL_ZOOM_LSB +: ZOOM_W] : '0;
  // Lower display area runs below the split line, upper area from the split line on.
  assign area_sel = (line_cnt_r >= line_r[SPLIT_LSB +: GEOM_W]);

  // Wide select per area from its own parameter byte.
  always_comb begin
    if (mode == MODE_CHARACTER) begin
      wide = area_sel ? wide_bit(area_r, AREA1_CHR_BYTE) : wide_bit(area_r, AREA0_CHR_BYTE);
    end else begin
      wide = area_sel ? wide_bit(area_r, AREA1_GFX_BYTE) : wide_bit(area_r, AREA0_GFX_BYTE);
    end
  end

  // Address step of two in wide mode.
  assign step = wide ? DAD_W'(2) : DAD_W'(1);

  zoom_cycle_timer #(
    .ZOOM_W(ZOOM_W)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .zoom_m1(zoom_m1),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // Write channel: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (aw_held_r && w_held_r) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (bus_req.awvalid && !aw_held_r && !bvalid_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= bus_req.awaddr;
      end
      if (bus_req.wvalid && !w_held_r && !bvalid_r) begin
        w_held_r <= 1'b1;
        wdata_r <= bus_req.wdata;
        wstrb_r <= bus_req.wstrb;
      end
    end
  end

  // Register writes and the write response; unmapped offsets answer with an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      area_r <= AREA_RST;
      line_r <= LINE_RST;
      start_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (aw_held_r && w_held_r) begin
      bvalid_r <= 1'b1;
      bresp_r <= RESP_OKAY;
      unique case (awaddr_r)
        CTRL_OFS: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
        AREA_OFS: area_r <= merge(area_r, wdata_r, wstrb_r);
        LINE_OFS: line_r <= merge(line_r, wdata_r, wstrb_r);
        START_OFS: start_r <= DAD_W'(merge(DATA_W'(start_r), wdata_r, wstrb_r));
        STATUS_OFS: bresp_r <= RESP_OKAY;
        default: bresp_r <= RESP_SLVERR;
      endcase
    end else if (bvalid_r && bus_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (bus_req.arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      unique case (bus_req.araddr)
        CTRL_OFS: rdata_r <= ctrl_r;
        AREA_OFS: rdata_r <= area_r;
        LINE_OFS: rdata_r <= line_r;
        START_OFS: rdata_r <= DATA_W'(start_r);
        STATUS_OFS: rdata_r <= {last_word_r, dad_r[AD_W-1:0]};
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && bus_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Display address walk; each line is scanned zoom-factor times.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      dad_r <= start_r;
      line_base_r <= start_r;
      word_cnt_r <= '0;
      line_cnt_r <= '0;
      rep_cnt_r <= '0;
    end else if (cycle_end) begin
      if (word_cnt_r == line_r[WORDS_LSB +: GEOM_W] - 8'h01) begin
        word_cnt_r <= '0;
        if (rep_cnt_r == zoom_m1) begin
          rep_cnt_r <= '0;
          line_base_r <= dad_r + step;
          dad_r <= dad_r + step;
          if (line_cnt_r == line_r[LINES_LSB +: GEOM_W] - 8'h01) begin
            line_cnt_r <= '0;
            line_base_r <= start_r;
            dad_r <= start_r;
          end else begin
            line_cnt_r <= line_cnt_r + 8'h01;
          end
        end else begin
          rep_cnt_r <= rep_cnt_r + 1'b1;
          dad_r <= line_base_r;
        end
      end else begin
        word_cnt_r <= word_cnt_r + 8'h01;
        dad_r <= dad_r + step;
      end
    end
  end

  // Pins lag the phase counter by one clock, so counter phases 0 and 1 give pin phases one
  // and two. The strobe resolves to whole clocks here, so it is low for all of phase one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_latch_r <= 1'b1;
    end else if (run && (phase == '0 || phase == (ZOOM_W+1)'(1))) begin
      addr_latch_r <= 1'b0;
    end else begin
      addr_latch_r <= 1'b1;
    end
  end

  // Address driven in phase one, bus released from phase two on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ad_out_r <= '0;
      ad_oe_n_r <= '1;
      addr_high_r <= '0;
    end else if (run && phase == '0) begin
      ad_out_r <= dad_r[AD_W-1:0];
      ad_oe_n_r <= '0;
      addr_high_r <= dad_r[DAD_W-1:AD_W];
    end else begin
      ad_oe_n_r <= '1;
    end
  end

  // Marks where the video side may load, and captures the fetched word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_window_r <= 1'b0;
      wide_cycle_r <= 1'b0;
      last_word_r <= '0;
    end else begin
      load_window_r <= run && (phase == (ZOOM_W+1)'(1));
      wide_cycle_r <= run && wide;
      if (load_window_r) begin
        last_word_r <= ad_in;
      end
    end
  end

  assign pins = '{ad_out: ad_out_r, ad_oe_n: ad_oe_n_r,
                  addr_latch: addr_latch_r, addr_high: addr_high_r};
  assign bus_rsp = '{awready: !aw_held_r && !bvalid_r, wready: !w_held_r && !bvalid_r,
                     bvalid: bvalid_r, bresp: bresp_r, arready: !rvalid_r,
                     rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

endmodule

// file: zoom_display_assertions.sv
module zoom_display_assertions
  import zoom_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire zoom_pkg::axil_req_t bus_req,
  input wire zoom_pkg::axil_rsp_t bus_rsp,
  input wire zoom_pkg::mem_pins_t pins,
  input wire logic wide_cycle_r,
  input wire logic load_window_r
);
  logic prev_oe_r;
  logic [5:0] gap_r;
  logic start;
  // A display cycle begins where the address drive begins.
  assign start = prev_oe_r && !pins.ad_oe_n[0];
  // Cycles since the last start; it saturates so long idle spans stay legal.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_oe_r <= 1'b1;
      gap_r <= 6'h02;
    end else begin
      prev_oe_r <= pins.ad_oe_n[0];
      gap_r <= start ? 6'h01 : (gap_r == 6'h3f ? gap_r : gap_r + 6'h01);
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_oe_uniform: assert property ((pins.ad_oe_n == '0) || (&pins.ad_oe_n))
    else $error("address lines not driven as one group");
  a_drive_strobe_low: assert property (!pins.ad_oe_n[0] |-> !pins.addr_latch)
    else $error("strobe high while address is driven");
  a_single_drive: assert property ($fell(pins.ad_oe_n[0]) |=> pins.ad_oe_n[0] && !pins.addr_latch)
    else $error("address lines not released in phase two");
  a_high_no_drive: assert property (pins.addr_latch |-> pins.ad_oe_n[0])
    else $error("address driven while strobe is high");
  a_load_follow: assert property (!pins.ad_oe_n[0] |-> ##1 load_window_r)
    else $error("load point missing after phase one");
  a_load_single: assert property (load_window_r |=> !load_window_r)
    else $error("load point wider than one cycle");
  a_cycle_min: assert property (start |-> gap_r >= 6'h02)
    else $error("display cycle shorter than two clocks");
  a_read_answer: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (bus_rsp.bvalid && !bus_req.bready |=> bus_rsp.bvalid)
    else $error("write response dropped early");
  c_long_cycle: cover property (start && gap_r == 6'h20);
  c_wide: cover property (wide_cycle_r && start);
  c_load: cover property (load_window_r);
endmodule

// file: zoom_video_model.sv
module zoom_video_model
  import zoom_pkg::*;
(
  input wire logic aclk,
  input wire zoom_pkg::mem_pins_t pins,
  input wire logic load_window_r,
  input wire logic [3:0] preset,
  output logic [zoom_pkg::AD_W-1:0] ad_in,
  output logic [zoom_pkg::AD_W-1:0] video_shift_register,
  output logic carry
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pre_r;
  initial begin
    ad_in = 16'h5a5a;
    video_shift_register = 16'h0000;
    pre_r = 4'h0;
  end
  // Data is valid only in phase two; after that the floating bus keeps changing.
  always @(posedge aclk) begin
    if (!pins.ad_oe_n[0]) begin
      ad_in <= ~pins.ad_out;
    end else begin
      ad_in <= {ad_in[14:0], ~ad_in[15]};
    end
  end
  assign carry = (pre_r == 4'hf);
  // The prescaler restarts on a word load so the first pixel is stretched fully.
  always @(posedge aclk) begin
    if (carry || load_window_r) begin
      pre_r <= preset;
    end else begin
      pre_r <= pre_r + 4'h1;
    end
  end
  // Shifting waits for the carry.
  always @(posedge aclk) begin
    if (load_window_r) begin
      video_shift_register <= ad_in;
    end else if (carry) begin
      video_shift_register <= {video_shift_register[14:0], 1'b0};
    end
  end
endmodule

// file: zoom_display_test.sv
module zoom_display_test
  import zoom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, wide, load_w, carry, ok;
  axil_req_t rq;
  axil_rsp_t rs;
  mem_pins_t pins;
  logic [AD_W-1:0] ad_in, video_shift_register, a0, a1, a2;
  logic [3:0] preset;
  logic [31:0] d;
  logic [1:0] r;
  int miscompares, total_checks, n, lo;
  int zt[4] = '{1, 2, 5, 16};
  zoom_display dut (.aclk(aclk), .aresetn(aresetn), .bus_req(rq), .bus_rsp(rs),
    .ad_in(ad_in), .pins(pins), .wide_cycle_r(wide), .load_window_r(load_w));
  zoom_video_model far (.aclk(aclk), .pins(pins), .load_window_r(load_w),
    .preset(preset), .ad_in(ad_in), .video_shift_register(video_shift_register), .carry(carry));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Address and data go out together; each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    logic aw_t, w_t, b_t;
    k = 0;
    @(posedge aclk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= v;
    rq.wstrb <= 4'hf;
    rq.bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = rs.awready && rq.awvalid;
      w_t = rs.wready && rq.wvalid;
      b_t = rs.bvalid;
      r = rs.bresp;
      @(posedge aclk);
      k++;
      if (aw_t) rq.awvalid <= 1'b0;
      if (w_t) rq.wvalid <= 1'b0;
    end while (!b_t && k < 200);
    rq.bready <= 1'b0;
    if (k >= 200) miscompares++;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    logic ar_t, r_t;
    k = 0;
    @(posedge aclk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = rs.arready && rq.arvalid;
      r_t = rs.rvalid;
      d = rs.rdata;
      r = rs.rresp;
      @(posedge aclk);
      k++;
      if (ar_t) rq.arvalid <= 1'b0;
    end while (!r_t && k < 200);
    rq.rready <= 1'b0;
    if (k >= 200) miscompares++;
  endtask
  // Waits for the next display cycle start; returns its span and address.
  task automatic nxt(output logic [AD_W-1:0] a);
    logic p, c;
    p = 1'b0;
    c = 1'b0;
    n = 0;
    lo = 0;
    do begin
      @(negedge aclk);
      p = c;
      c = pins.ad_oe_n[0];
      a = pins.ad_out;
      n++;
      if (!pins.addr_latch) lo++;
    end while (!(p && !c && n > 1) && n < 100);
  endtask
  initial begin
    rq = '0;
    preset = 4'hf;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS);
    chk(d, CTRL_RST);
    rd(AREA_OFS);
    chk(d, AREA_RST);
    rd(LINE_OFS);
    chk(d, LINE_RST);
    rd(8'h14);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0000_0000);
    wr(8'h14, 32'h0000_0001);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    foreach (zt[i]) begin
      preset <= 4'(16 - zt[i]);
      wr(CTRL_OFS, 32'(((zt[i] - 1) << 4) | 1));
      repeat (3) nxt(a0);
      chk(32'(n), 32'(2 * zt[i]));
      chk(32'(lo), 32'd2);
      repeat (2) @(posedge aclk);
      #1;
      chk({16'h0, video_shift_register}, {16'h0, ~a0});
    end
    $display("test zoom done");
    wr(CTRL_OFS, 32'h0000_0033);
    repeat (3) nxt(a0);
    chk(32'(n), 32'd2);
    $display("test character done");
    preset <= 4'hf;
    wr(CTRL_OFS, 32'h0000_0001);
    wr(AREA_OFS, 32'h8080_8080);
    repeat (2) nxt(a0);
    nxt(a1);
    nxt(a2);
    ok = (a1 - a0 == 16'h2) || (a2 - a1 == 16'h2);
    chk({31'h0, wide}, 32'h1);
    chk({31'h0, ok}, 32'h1);
    wr(AREA_OFS, 32'h0000_0000);
    repeat (2) nxt(a0);
    nxt(a1);
    nxt(a2);
    ok = (a1 - a0 == 16'h1) || (a2 - a1 == 16'h1);
    chk({31'h0, wide}, 32'h0);
    chk({31'h0, ok}, 32'h1);
    $display("test wide done");
    wrap_up;
  end
  // The whole run needs a few hundred clocks.
  initial begin
    #(100 * 20000);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
bind zoom_display zoom_display_assertions chk_i (.aclk(aclk), .aresetn(aresetn),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .pins(pins), .wide_cycle_r(wide_cycle_r),
  .load_window_r(load_window_r));
